// ==== rtl/lvds_serdes_link.sv ====
// Functional notes
// - Each lane bit lasts one seventh strobe period; here one clk_sys period, whatever the strobe rate
// - Transmitter waits 10 ms before toggling outputs
// - Power-down low enters power-down at any time
// - Floating data lanes with clock give ones
// - Floating clock and data hold last word
// - Floating forwarded clock holds strobe output high
// - Lost transmitter power keeps receiver outputs held
// - Receiver power-down forces parallel outputs low
// - Transmitter power-down releases serial outputs
// - Rising strobe edges sample words; received words change on falling strobe edges
`timescale 1ns/1ps
`include "lvds_link_map.svh"

module lvds_serdes_link #(
    parameter int LANES = `LINK_LANES,
    parameter int SLOTS = `LINK_SLOTS,
    parameter int WORD_W = `WORD_BITS,
    parameter int PLL_WAIT_CYCLES = `PLL_WAIT_CYCLES
) (
    input wire logic clk_sys, // Bit clock, 50 MHz
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic power_down_n, // Power-down pin, active low
    input wire logic tx_strobe_clock_in, // Transmit word strobe clock
    input wire logic [WORD_W-1:0] parallel_word_in, // Word to send
    output logic [LANES-1:0] serial_lane_out, // Transmit data lanes
    output logic serial_lane_oe, // Lane output enable
    output logic serial_clock_out, // Forwarded clock lane
    output logic serial_clock_oe, // Forwarded clock output enable
    output logic tx_locked, // Transmitter past its lock wait
    input wire logic [LANES-1:0] serial_lane_in, // Receive data lanes
    input wire logic serial_clock_in, // Received forwarded clock
    output logic [WORD_W-1:0] parallel_word_out, // Received word
    output logic rx_strobe_clock_out, // Recovered word strobe
    output logic rx_aligned // Receiver aligned to forwarded clock
);

    // ================================================================
    // Lane and slot to word bit: lane-major, slot 0 first on the wire
    function automatic int bit_index(input int lane, input int slot);
        bit_index = lane * SLOTS + slot;
    endfunction : bit_index

    localparam logic [`WAIT_CNT_W-1:0] WAIT_LAST =
        `WAIT_CNT_W'(PLL_WAIT_CYCLES - 1);
    localparam logic [`SLOT_W-1:0] SLOT_LAST = `SLOT_W'(SLOTS - 1);

    // ================================================================
    // Slot decoding shared by the transmit and receive halves
    function automatic logic is_last_slot(input logic [`SLOT_W-1:0] slot);
        is_last_slot = (slot == SLOT_LAST);
    endfunction : is_last_slot

    // Receive slot stops at the last slot when an edge is late, so a
    // stretched frame never writes over its own first bits
    function automatic logic [`SLOT_W-1:0] rx_slot_step(
        input logic [`SLOT_W-1:0] slot
    );
        rx_slot_step = is_last_slot(slot) ? slot : slot + 1'b1;
    endfunction : rx_slot_step

    // Transmit slot wraps at the end of every frame
    function automatic logic [`SLOT_W-1:0] tx_slot_step(
        input logic [`SLOT_W-1:0] slot
    );
        tx_slot_step = is_last_slot(slot) ? '0 : slot + 1'b1;
    endfunction : tx_slot_step

    function automatic logic fwd_clk_level(input logic [`SLOT_W-1:0] slot);
        fwd_clk_level = (slot < `FWD_CLK_HIGH_SLOTS);
    endfunction : fwd_clk_level

    // Lane bits of one slot of a frame; both ends must use the same
    // order, so the transmitter and receiver share bit_index
    function automatic logic [LANES-1:0] frame_lanes(
        input logic [WORD_W-1:0] frame,
        input logic [`SLOT_W-1:0] slot
    );
        frame_lanes = '0;
        for (int l = 0; l < LANES; l++)
        begin
            frame_lanes[l] = frame[bit_index(l, int'(slot))];
        end
    endfunction : frame_lanes

    // Frame with the lane bits of one slot written in; bits of other
    // slots keep what the earlier cycles of the frame stored
    function automatic logic [WORD_W-1:0] frame_store(
        input logic [WORD_W-1:0] frame,
        input logic [`SLOT_W-1:0] slot,
        input logic [LANES-1:0] lanes
    );
        frame_store = frame;
        for (int l = 0; l < LANES; l++)
        begin
            frame_store[bit_index(l, int'(slot))] = lanes[l];
        end
    endfunction : frame_store

    lvds_link_pkg::sys_state_t st_r;
    lvds_link_pkg::sys_state_t st_nxt;

    logic [WORD_W-1:0] strobe_word;
    logic strobe_fresh;
    logic ck_rise;
    logic clk_lost;
    logic pd_active;

    // ================================================================
    // Strobe clock crossing
    strobe_word_cross #(
        .WORD_W(WORD_W)
    ) u_cross (
        .clk_sys(clk_sys),
        .rst_b(rst_b),
        .tx_strobe_clock_in(tx_strobe_clock_in),
        .parallel_word_in(parallel_word_in),
        .word_out(strobe_word),
        .word_fresh(strobe_fresh)
    );

    // ================================================================
    // Forwarded clock edge, loss and power-down decode
    assign pd_active = ~st_r.pd_s;
    assign ck_rise = st_r.ck_s & ~st_r.ck_prev;
    // Failsafe bias makes a floating clock read high, so no edges come;
    // a far end slower than two frames per edge would also read as lost
    assign clk_lost = (st_r.loss_cnt >= `CLK_LOSS_CYCLES);

    // ================================================================
    // Next state
    always_comb
    begin
        st_nxt = st_r;

        // ------------------------------------------------------------
        // Input synchronisers
        // Pins are asynchronous to clk_sys
        st_nxt.pd_meta = power_down_n;
        st_nxt.pd_s = st_r.pd_meta;
        st_nxt.lane_meta = serial_lane_in;
        st_nxt.lane_s = st_r.lane_meta;
        st_nxt.ck_meta = serial_clock_in;
        st_nxt.ck_s = st_r.ck_meta;
        st_nxt.ck_prev = st_r.ck_s;

        // ------------------------------------------------------------
        // Transmitter
        // The newest strobed word wins: a strobe faster than a frame drops
        // words, a slower one has its word sent again
        if (strobe_fresh)
        begin
            st_nxt.tx_hold = strobe_word;
        end

        if (pd_active)
        begin
            // Entered at once, whatever frame is in flight
            st_nxt.tx_mode = lvds_link_pkg::TX_OFF;
            st_nxt.tx_oe = 1'b0;
            st_nxt.tx_out = '0;
            st_nxt.wait_cnt = '0;
            st_nxt.tx_slot = '0;
        end
        else
        begin
            unique case (st_r.tx_mode)
                lvds_link_pkg::TX_OFF:
                begin
                    // Release restarts the lock wait, which is what lets a
                    // restored strobe clock relock
                    st_nxt.tx_mode = lvds_link_pkg::TX_LOCK;
                    st_nxt.wait_cnt = '0;
                    st_nxt.tx_oe = 1'b1;
                    st_nxt.tx_out = '0;
                end
                lvds_link_pkg::TX_LOCK:
                begin
                    // The wait stands in for the PLL, which is not modelled
                    if (st_r.wait_cnt == WAIT_LAST)
                    begin
                        st_nxt.tx_mode = lvds_link_pkg::TX_RUN;
                        st_nxt.tx_slot = SLOT_LAST;
                    end
                    else
                    begin
                        st_nxt.wait_cnt = st_r.wait_cnt + 1'b1;
                    end
                end
                lvds_link_pkg::TX_RUN:
                begin
                    // One bit per clk_sys, seven per frame
                    st_nxt.tx_slot = tx_slot_step(st_r.tx_slot);
                    if (is_last_slot(st_r.tx_slot))
                    begin
                        st_nxt.tx_frame = st_r.tx_hold;
                    end
                    st_nxt.tx_out.lane =
                        frame_lanes(st_nxt.tx_frame, st_nxt.tx_slot);
                    st_nxt.tx_out.clk = fwd_clk_level(st_nxt.tx_slot);
                end
                default:
                begin
                    st_nxt.tx_mode = lvds_link_pkg::TX_OFF;
                end
            endcase
        end

        // ------------------------------------------------------------
        // Receiver
        // Bit rate is taken to be clk_sys: with no recovery PLL, a far end
        // on another bit clock still aligns, but its bits are taken in the wrong slots
        if (pd_active)
        begin
            st_nxt.rx_word = '0;
            st_nxt.rx_clk = 1'b0;
            st_nxt.aligned = 1'b0;
            st_nxt.edges = '0;
            st_nxt.loss_cnt = '0;
            st_nxt.rx_slot = '0;
        end
        else if (ck_rise)
        begin
            st_nxt.loss_cnt = '0;
            st_nxt.rx_slot = '0;
            if (st_r.edges != `ALIGN_EDGES)
            begin
                st_nxt.edges = st_r.edges + 1'b1;
            end
            // Previous frame is complete; floating data lanes read high,
            // so a live clock with dead data gives all ones
            if (st_r.aligned)
            begin
                st_nxt.rx_word = st_r.rx_shift;
                st_nxt.rx_clk = 1'b0;
            end
            st_nxt.aligned = (st_nxt.edges == `ALIGN_EDGES);
        end
        else
        begin
            if (!clk_lost)
            begin
                st_nxt.loss_cnt = st_r.loss_cnt + 1'b1;
            end
            st_nxt.rx_slot = rx_slot_step(st_r.rx_slot);
            if (st_nxt.rx_slot == `RX_CLK_RISE_SLOT)
            begin
                st_nxt.rx_clk = 1'b1;
            end
        end

        if (!pd_active)
        begin
            st_nxt.rx_shift = frame_store(st_r.rx_shift, st_nxt.rx_slot,
                st_r.lane_s);
            if (clk_lost)
            begin
                // A far end that lost power looks the same: its clock stops
                // Word register is left alone: last good word stays out
                st_nxt.rx_clk = 1'b1;
                st_nxt.aligned = 1'b0;
                st_nxt.edges = '0;
            end
            if (!st_r.aligned && !st_nxt.aligned && !clk_lost)
            begin
                st_nxt.rx_clk = 1'b1;
            end
        end

        if (!rst_b)
        begin
            st_nxt = '0;
            st_nxt.tx_mode = lvds_link_pkg::TX_OFF;
            // Released pairs read high through the failsafe bias; starting
            // the synchronisers at that level keeps a false clock edge
            // from counting towards alignment after reset
            st_nxt.ck_meta = 1'b1;
            st_nxt.ck_s = 1'b1;
            st_nxt.ck_prev = 1'b1;
            st_nxt.lane_meta = '1;
            st_nxt.lane_s = '1;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        st_r <= st_nxt;
    end

    // ================================================================
    // Outputs
    assign serial_lane_out = st_r.tx_out.lane;
    assign serial_clock_out = st_r.tx_out.clk;
    // One enable serves lanes and forwarded clock, so both are released
    // in the same cycle; the pad turns a low enable into high impedance
    assign serial_lane_oe = st_r.tx_oe;
    assign serial_clock_oe = st_r.tx_oe;
    assign tx_locked = (st_r.tx_mode == lvds_link_pkg::TX_RUN);
    assign parallel_word_out = st_r.rx_word;
    assign rx_strobe_clock_out = st_r.rx_clk;
    assign rx_aligned = st_r.aligned;

endmodule : lvds_serdes_link

// ==== rtl/lvds_link_map.svh ====
`ifndef LVDS_LINK_MAP_SVH
`define LVDS_LINK_MAP_SVH

// ====================================================================
// Link geometry
`define LINK_LANES 3
`define LINK_SLOTS 7
`define WORD_BITS 21
`define SLOT_W 3
// Forwarded clock is high for the first slots of each frame
`define FWD_CLK_HIGH_SLOTS 3'h4
// Recovered strobe rises at this slot, mid-way through a stable word
`define RX_CLK_RISE_SLOT 3'h3

// ====================================================================
// Timing
`define SYS_CLK_HZ 50_000_000
`define PLL_WAIT_MS 10
`define PLL_WAIT_CYCLES ((`SYS_CLK_HZ / 1000) * `PLL_WAIT_MS)
`define WAIT_CNT_W 20
// Two frames without a forwarded clock edge means the clock is gone
`define CLK_LOSS_CYCLES 4'he
`define LOSS_CNT_W 4
// Rising edges of the forwarded clock seen before words are presented
`define ALIGN_EDGES 2'h2

`endif

// ==== rtl/lvds_link_pkg.sv ====
package lvds_link_pkg;

`include "lvds_link_map.svh"

    typedef enum logic [1:0] {TX_OFF, TX_LOCK, TX_RUN} tx_mode_t;

    typedef struct packed {
        logic [`LINK_LANES-1:0] lane;
        logic clk;
    } serial_bus_t;

    typedef struct packed {
        // Input synchronisers
        logic pd_meta;
        logic pd_s;
        logic [`LINK_LANES-1:0] lane_meta;
        logic [`LINK_LANES-1:0] lane_s;
        logic ck_meta;
        logic ck_s;
        logic ck_prev;
        // Transmitter
        tx_mode_t tx_mode;
        logic [`WAIT_CNT_W-1:0] wait_cnt;
        logic [`SLOT_W-1:0] tx_slot;
        logic [`WORD_BITS-1:0] tx_hold;
        logic [`WORD_BITS-1:0] tx_frame;
        serial_bus_t tx_out;
        logic tx_oe;
        // Receiver
        logic [`SLOT_W-1:0] rx_slot;
        logic [`WORD_BITS-1:0] rx_shift;
        logic [`WORD_BITS-1:0] rx_word;
        logic rx_clk;
        logic [`LOSS_CNT_W-1:0] loss_cnt;
        logic [1:0] edges;
        logic aligned;
    } sys_state_t;

    typedef struct packed {
        logic rst_meta;
        logic rst_s;
        logic tog;
        logic [`WORD_BITS-1:0] word;
    } strobe_state_t;

    typedef struct packed {
        logic tog_meta;
        logic tog_s;
        logic tog_prev;
        logic [`WORD_BITS-1:0] word;
        logic fresh;
    } cross_state_t;

endpackage : lvds_link_pkg

// ==== rtl/strobe_word_cross.sv ====
`timescale 1ns/1ps
`include "lvds_link_map.svh"

module strobe_word_cross #(
    parameter int WORD_W = `WORD_BITS
) (
    input wire logic clk_sys, // System clock
    input wire logic rst_b, // Synchronous reset, active low
    input wire logic tx_strobe_clock_in, // Parallel word strobe clock
    input wire logic [WORD_W-1:0] parallel_word_in, // Word at the strobe
    output logic [WORD_W-1:0] word_out, // Latest word, system domain
    output logic word_fresh // One-cycle pulse when word_out renews
);

    lvds_link_pkg::strobe_state_t lk_r;
    lvds_link_pkg::strobe_state_t lk_nxt;
    lvds_link_pkg::cross_state_t sy_r;
    lvds_link_pkg::cross_state_t sy_nxt;

    // ================================================================
    // Strobe domain: capture and announce by toggle
    // The word register is stable for a full strobe period, longer than
    // the toggle takes to cross, so the system side reads it directly.
    always_comb
    begin
        lk_nxt = lk_r;
        lk_nxt.rst_meta = rst_b;
        lk_nxt.rst_s = lk_r.rst_meta;
        if (!lk_r.rst_s)
        begin
            lk_nxt.tog = 1'b0;
            lk_nxt.word = '0;
        end
        else
        begin
            lk_nxt.word = parallel_word_in;
            lk_nxt.tog = ~lk_r.tog;
        end
    end

    always_ff @(posedge tx_strobe_clock_in)
    begin
        lk_r <= lk_nxt;
    end

    // ================================================================
    // System domain: detect the toggle and take the word
    always_comb
    begin
        sy_nxt = sy_r;
        sy_nxt.tog_meta = lk_r.tog;
        sy_nxt.tog_s = sy_r.tog_meta;
        sy_nxt.tog_prev = sy_r.tog_s;
        sy_nxt.fresh = sy_r.tog_s ^ sy_r.tog_prev;
        if (sy_r.tog_s ^ sy_r.tog_prev)
        begin
            sy_nxt.word = lk_r.word;
        end
        if (!rst_b)
        begin
            sy_nxt = '0;
        end
    end

    always_ff @(posedge clk_sys)
    begin
        sy_r <= sy_nxt;
    end

    assign word_out = sy_r.word;
    assign word_fresh = sy_r.fresh;

endmodule : strobe_word_cross

// ==== bench/lvds_serdes_link_monitor.sv ====
`timescale 1ns/1ps
module lvds_serdes_link_monitor #(
    parameter int PLL_WAIT_CYCLES = 20
) (
    input wire logic clk_sys, // Bit clock
    input wire logic rst_b, // Reset, active low
    input wire logic power_down_n, // Power-down pin
    input wire logic [2:0] serial_lane_out, // Lanes
    input wire logic serial_lane_oe, // Lane enable
    input wire logic serial_clock_out, // Forwarded clock
    input wire logic serial_clock_oe, // Clock enable
    input wire logic tx_locked, // Lock wait over
    input wire logic [20:0] parallel_word_out, // Received word
    input wire logic rx_strobe_clock_out, // Recovered strobe
    input wire logic rx_aligned // Receiver aligned
);
    // ================================================================
    // Lock wait counter
    logic [19:0] lk_r;
    logic [19:0] lk_nxt;
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_b);
    always_comb
    begin
        lk_nxt = tx_locked ? lk_r : lk_r + 20'h0_0001;
        if (!serial_lane_oe)
            lk_nxt = 20'h0_0000;
    end
    always_ff @(posedge clk_sys)
        lk_r <= rst_b ? lk_nxt : 20'h0_0000;
    // ================================================================
    // Checks
    oe_pair_a: assert property (serial_clock_oe == serial_lane_oe)
        else $error("enables differ");
    pd_release_a: assert property (!power_down_n [*4] |->
        !serial_lane_oe && !tx_locked) else $error("tx still on");
    pd_rx_low_a: assert property (!power_down_n [*4] |->
        parallel_word_out == 21'h00_0000 && !rx_strobe_clock_out)
        else $error("rx not low");
    idle_lock_a: assert property (serial_lane_oe && !tx_locked |->
        serial_lane_out == 3'h0) else $error("lanes before lock");
    lock_wait_a: assert property ($rose(tx_locked) |->
        lk_r >= PLL_WAIT_CYCLES - 1 && lk_r <= PLL_WAIT_CYCLES + 1)
        else $error("lock wait length");
    // Power-down cuts a frame short, so the shape is only kept outside it
    frame_clk_a: assert property (disable iff (!rst_b || !power_down_n)
        $rose(serial_clock_out) && tx_locked |-> ##1 serial_clock_out [*3]
        ##1 !serial_clock_out [*3] ##1 serial_clock_out)
        else $error("frame clock shape");
    lost_high_a: assert property ($fell(rx_aligned) && power_down_n |->
        ##[0:1] rx_strobe_clock_out) else $error("strobe not high");
    hold_lost_a: assert property (!rx_aligned && power_down_n |=>
        $stable(parallel_word_out) || rx_aligned) else $error("word moved");
    word_edge_a: assert property ($changed(parallel_word_out) &&
        rx_aligned && $past(rx_aligned) |-> !rx_strobe_clock_out)
        else $error("word changed off edge");
    strobe_rise_a: assert property ($fell(rx_strobe_clock_out) &&
        rx_aligned && power_down_n |-> ##[2:4] rx_strobe_clock_out)
        else $error("strobe not back high");
endmodule : lvds_serdes_link_monitor

bind lvds_serdes_link lvds_serdes_link_monitor #(
    .PLL_WAIT_CYCLES(PLL_WAIT_CYCLES)
) mon_u (.clk_sys(clk_sys), .rst_b(rst_b), .power_down_n(power_down_n),
    .serial_lane_out(serial_lane_out), .serial_lane_oe(serial_lane_oe),
    .serial_clock_out(serial_clock_out), .serial_clock_oe(serial_clock_oe),
    .tx_locked(tx_locked), .parallel_word_out(parallel_word_out),
    .rx_strobe_clock_out(rx_strobe_clock_out), .rx_aligned(rx_aligned));

// ==== bench/lvds_cable_model.sv ====
`timescale 1ns/1ps
module lvds_cable_model (
    input wire logic [2:0] lane_drv, // Driver lanes
    input wire logic lane_oe, // Driver lane enable
    input wire logic clk_drv, // Driver forwarded clock
    input wire logic clk_oe, // Driver clock enable
    input wire logic float_data, // Data pairs cut
    input wire logic float_clk, // Clock pair cut
    output logic [2:0] lane_rcv, // Receiver lanes
    output logic clk_rcv // Receiver clock
);
    // ================================================================
    // Failsafe bias reads a released or cut pair as high
    assign lane_rcv = (lane_oe && !float_data) ? lane_drv : 3'h7;
    assign clk_rcv = (clk_oe && !float_clk) ? clk_drv : 1'b1;
endmodule : lvds_cable_model

// ==== bench/test_lvds_serdes_link.sv ====
`timescale 1ns/1ps
module test_lvds_serdes_link;
    localparam int WAIT_N = 20;
    logic clk_sys = 0, rst_b = 0, power_down_n = 1, strobe = 0, run = 1;
    logic float_data = 0, float_clk = 0, lane_oe, ck_out, ck_oe, locked;
    logic ck_in, rx_ck, aligned;
    logic [2:0] lane_out, lane_in;
    logic [20:0] word_in = 21'h00_0000, word_out;
    int error_cnt = 0, check_count = 0, cycles = 0;
    lvds_serdes_link #(.PLL_WAIT_CYCLES(WAIT_N)) dut_u (.clk_sys(clk_sys),
        .rst_b(rst_b), .power_down_n(power_down_n),
        .tx_strobe_clock_in(strobe), .parallel_word_in(word_in),
        .serial_lane_out(lane_out), .serial_lane_oe(lane_oe),
        .serial_clock_out(ck_out), .serial_clock_oe(ck_oe),
        .tx_locked(locked), .serial_lane_in(lane_in), .serial_clock_in(ck_in),
        .parallel_word_out(word_out), .rx_strobe_clock_out(rx_ck),
        .rx_aligned(aligned));
    lvds_cable_model cable_u (.lane_drv(lane_out), .lane_oe(lane_oe),
        .clk_drv(ck_out), .clk_oe(ck_oe), .float_data(float_data),
        .float_clk(float_clk), .lane_rcv(lane_in), .clk_rcv(ck_in));
    // ================================================================
    // Clocks and watchdog
    initial
        forever #10 clk_sys = ~clk_sys;
    // Strobe runs whenever the transmitter is enabled
    initial
    begin
        #7;
        forever #40 if (run) strobe = ~strobe;
    end
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            error_cnt++;
            final_report();
        end
    end
    // ================================================================
    // Helpers
    task final_report;
        $display("errors %0d checks %0d", error_cnt, check_count);
        if (error_cnt == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : final_report
    task cmp_word(input logic [20:0] exp, input logic [20:0] got);
        check_count++;
        if (got !== exp)
        begin
            error_cnt++;
            $display("mismatch t=%0t exp=%h got=%h", $time, exp, got);
        end
    endtask : cmp_word
    task cmp_bit(input logic exp, input logic got);
        cmp_word({20'h0_0000, exp}, {20'h0_0000, got});
    endtask : cmp_bit
    task step(input int n);
        repeat (n) @(negedge clk_sys);
    endtask : step
    // ================================================================
    // Scenarios
    task t_lock;
        int n;
        n = 0;
        rst_b = 1;
        while (locked !== 1'b1 && n < 200)
        begin
            step(1);
            n++;
            if (lane_oe === 1'b1 && locked !== 1'b1)
                cmp_word(21'h00_0000, {18'h0_0000, lane_out});
        end
        cmp_bit(1'b1, n >= WAIT_N && n <= WAIT_N + 6);
    endtask : t_lock
    // Walks one frame slot by slot, then the word through the cable
    task t_data(input logic [20:0] w);
        logic p;
        word_in = w;
        step(30);
        p = ck_out;
        for (int i = 0; i < 20; i++)
        begin
            step(1);
            if (ck_out === 1'b1 && p === 1'b0)
                break;
            p = ck_out;
        end
        for (int k = 0; k < 7; k++)
        begin
            cmp_word({18'h0_0000, w[14+k], w[7+k], w[k]},
                {18'h0_0000, lane_out});
            cmp_bit(k < 4, ck_out);
            step(1);
        end
        for (int i = 0; i < 100 && aligned !== 1'b1; i++)
            step(1);
        step(30);
        cmp_word(w, word_out);
    endtask : t_data
    task t_float_data;
        float_data = 1;
        step(40);
        cmp_word(21'h1F_FFFF, word_out);
        float_data = 0;
        step(40);
    endtask : t_float_data
    // Cut while the clock is high so no false edge reaches the receiver
    task t_float_all(input logic [20:0] w);
        t_data(w);
        for (int i = 0; i < 10 && ck_out !== 1'b1; i++)
            step(1);
        float_clk = 1;
        float_data = 1;
        step(40);
        cmp_word(w, word_out);
        cmp_bit(1'b1, rx_ck);
        cmp_bit(1'b0, aligned);
        float_clk = 0;
        float_data = 0;
    endtask : t_float_all
    task t_pd(input logic [20:0] w);
        power_down_n = 0;
        step(6);
        cmp_bit(1'b0, lane_oe);
        cmp_bit(1'b0, ck_oe);
        cmp_word(21'h00_0000, word_out);
        cmp_bit(1'b0, rx_ck);
        run = 0;
        word_in = w;
        step(20);
        run = 1;
        step(10);
        power_down_n = 1;
        t_lock();
        t_data(w);
    endtask : t_pd
    initial
    begin
        step(16);
        cmp_word(21'h00_0000, word_out);
        cmp_bit(1'b0, lane_oe);
        cmp_bit(1'b0, locked);
        t_lock();
        t_data(21'h15_A5C3);
        t_data(21'h0A_5A3C);
        t_float_data();
        t_float_all(21'h1C_0F37);
        t_pd(21'h03_E1D9);
        final_report();
    end
endmodule : test_lvds_serdes_link
